// File: design/rcs_consts.svh
// Constants for the receive clock selection block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// Channel layout; tracker index 4 is the reference clock
`define RCS_NUM_CH        4
`define RCS_NUM_TRK       5
`define RCS_REF_IDX       3'h4
`define RCS_CH_A          3'h0
`define RCS_CH_B          3'h1
`define RCS_CH_C          3'h2
`define RCS_CH_D          3'h3

// Receive operating mode numbers that classify the bonding arrangement
`define RCS_MODE_INDEP0   4'h0
`define RCS_MODE_INDEP2   4'h2
`define RCS_MODE_DUAL3    4'h3
`define RCS_MODE_DUAL5    4'h5
`define RCS_MODE_QUAD6    4'h6
`define RCS_MODE_QUAD8    4'h8

// Raw character layout when the decoder is bypassed
`define RCS_RAW_W         10
`define RCS_RAW_DATA_MSB  9
`define RCS_RAW_DATA_LSB  2

// Width of the static input synchroniser vector
`define RCS_STATIC_W      11

// Reset values of the pin drivers and output registers
`define RCS_RST_PIN       4'h0
`define RCS_RST_DATA      8'h00
`define RCS_RST_STAT      3'h0

`endif

// File: design/rcs_pkg.sv
// Types for the receive clock selection block.
// Assumes rcs_consts.svh is on the include path.
`include "rcs_consts.svh"

package rcs_pkg;

    // Three-level static select, two-bit code; 2'b11 is not a legal level
    typedef enum logic [1:0] {
        RCS_LVL_LOW  = 2'b00,
        RCS_LVL_MID  = 2'b01,
        RCS_LVL_HIGH = 2'b10
    } rcs_level_e;

    // Bonding arrangement derived from the receive operating mode
    typedef enum logic [1:0] {
        RCS_BOND_INDEP = 2'b00,
        RCS_BOND_DUAL  = 2'b01,
        RCS_BOND_QUAD  = 2'b10,
        RCS_BOND_OTHER = 2'b11
    } rcs_bond_e;

    typedef logic [2:0] rcs_src_t;

endpackage : rcs_pkg

// File: design/rcs_clk_if.sv
// Interface between the selector and one clock tracker.
// Assumes the raw clock is driven by the selector and sampled on i_clk.
`timescale 1ns/1ns

interface rcs_clk_if;
    logic raw;
    logic level;
    logic rise;
    logic half_level;

    modport tracker (input raw, output level, output rise, output half_level);
    modport user    (output raw, input level, input rise, input half_level);
endinterface : rcs_clk_if

// File: design/rcs_clock_tracker.sv
// Samples one foreign clock, finds its rising edges and divides it by two.
// Assumes the foreign clock is far slower than i_clk.
`timescale 1ns/1ns

module rcs_clock_tracker (
    input wire logic  i_clk,
    input wire logic  i_reset,
    rcs_clk_if.tracker trk
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic half_r;

    // ==========================================================
    // Synchroniser and edge history
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= trk.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ==========================================================
    // Half-rate copy toggles on each rising edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            half_r <= 1'b0;
        end else if (s2_r && !s3_r) begin
            half_r <= ~half_r;
        end
    end

    assign trk.level      = s2_r;
    assign trk.rise       = s2_r & ~s3_r;
    assign trk.half_level = half_r;
endmodule : rcs_clock_tracker

// File: design/rcs_receive_clock_select.sv
// Receive clock selection: picks the clock that loads the four channel
// output registers and drives the four receive clock pin pairs.
// Assumes all clocks and static selects arrive from pins outside i_clk;
// channel character inputs come from logic on i_clk.
//
// Functional notes
// - A three-level static select picks the clock that loads the four output registers.
// - At MID each pin pair drives true and complement of its own channel's recovered clock.
// - In recovered modes the pin clocks run freely at character or half character rate.
// - At LOW all four output registers load from the reference clock.
// - At LOW the channel B and D clock drivers are disabled.
// - At LOW pins A and C carry copies of the reference clock slightly apart in phase.
// - At HIGH outside dual bonding the B and D positive pins are static master-select inputs.
// - At HIGH in quad or independent modes pins A and C carry one chosen recovered clock.
// - At HIGH in dual modes pin A carries clock A or B and pin C carries clock C or D.
// - At HIGH in dual mode the pair clock loads the bonded output data of both pair channels.
// - At HIGH the chosen clock runs at character or half rate per the rate select.
// - Rate LOW gives character-rate clocks, rate HIGH half-rate clocks for alternate capture.
// - When the reference clock is selected the rate select is ignored.
// - With the decoder mode LOW raw ten-bit characters pass to the output registers.
`timescale 1ns/1ns
`include "rcs_consts.svh"

module rcs_receive_clock_select
    import rcs_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [1:0]       i_output_clock_source_select,
    input  wire logic             i_recovered_clock_rate_select,
    input  wire logic [1:0]       i_decoder_mode_select,
    input  wire logic [3:0]       i_rx_mode,
    input  wire logic             i_reference_clock_in,
    input  wire logic [3:0]       i_recovered_clock,
    input  wire logic [3:0][9:0]  i_raw_char,
    input  wire logic [3:0]       i_raw_comma,
    input  wire logic [3:0][7:0]  i_dec_data,
    input  wire logic [3:0][2:0]  i_dec_status,
    input  wire logic [3:0]       i_dec_parity,
    input  wire logic [3:0]       i_rx_clock_pin_pair_p,
    output logic      [3:0]       o_rx_clock_pin_pair_p,
    output logic      [3:0]       o_rx_clock_pin_pair_n,
    output logic      [3:0]       o_rx_clock_pin_pair_oe,
    output logic      [3:0][7:0]  o_channel_parallel_data_out,
    output logic      [3:0][2:0]  o_channel_status_out,
    output logic      [3:0]       o_channel_odd_parity_out,
    output logic      [3:0]       o_channel_load
);
    // ==========================================================
    // Static input synchroniser
    logic [`RCS_STATIC_W-1:0] static_s1_r;
    logic [`RCS_STATIC_W-1:0] static_s2_r;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            static_s1_r <= '0;
            static_s2_r <= '0;
        end else begin
            static_s1_r <= {i_output_clock_source_select, i_recovered_clock_rate_select,
                            i_decoder_mode_select, i_rx_mode,
                            i_rx_clock_pin_pair_p[3], i_rx_clock_pin_pair_p[1]};
            static_s2_r <= static_s1_r;
        end
    end

    logic [1:0] src_sel_raw;
    logic       rate_half;
    logic [1:0] dec_raw;
    logic [3:0] rx_mode;
    logic       pin_b_sel;
    logic       pin_d_sel;

    assign src_sel_raw = static_s2_r[10:9];
    assign rate_half   = static_s2_r[8];
    assign dec_raw     = static_s2_r[7:6];
    assign rx_mode     = static_s2_r[5:2];
    assign pin_d_sel   = static_s2_r[1];
    assign pin_b_sel   = static_s2_r[0];

    // ==========================================================
    // Clock trackers: four recovered clocks and the reference
    rcs_clk_if trk_if [`RCS_NUM_TRK] ();
    logic [`RCS_NUM_TRK-1:0] trk_level;
    logic [`RCS_NUM_TRK-1:0] trk_rise;
    logic [`RCS_NUM_TRK-1:0] trk_half;

    genvar g;
    generate
        for (g = 0; g < `RCS_NUM_TRK; g++) begin : g_trk
            if (g < `RCS_NUM_CH) begin : g_rec
                assign trk_if[g].raw = i_recovered_clock[g];
            end else begin : g_ref
                assign trk_if[g].raw = i_reference_clock_in;
            end
            rcs_clock_tracker u_trk (
                .i_clk   (i_clk),
                .i_reset (i_reset),
                .trk     (trk_if[g].tracker)
            );
            assign trk_level[g] = trk_if[g].level;
            assign trk_rise[g]  = trk_if[g].rise;
            assign trk_half[g]  = trk_if[g].half_level;
        end
    endgenerate

    // ==========================================================
    // Mode decode
    rcs_level_e src_sel;
    rcs_bond_e  bond;
    logic       dec_bypass;

    always_comb begin
        unique case (src_sel_raw)
            2'b00:   src_sel = RCS_LVL_LOW;
            2'b01:   src_sel = RCS_LVL_MID;
            2'b10:   src_sel = RCS_LVL_HIGH;
            default: src_sel = RCS_LVL_MID;
        endcase
    end

    always_comb begin
        unique case (rx_mode)
            `RCS_MODE_INDEP0, `RCS_MODE_INDEP2: bond = RCS_BOND_INDEP;
            `RCS_MODE_DUAL3, `RCS_MODE_DUAL5:   bond = RCS_BOND_DUAL;
            `RCS_MODE_QUAD6, `RCS_MODE_QUAD8:   bond = RCS_BOND_QUAD;
            default:                            bond = RCS_BOND_OTHER;
        endcase
    end

    assign dec_bypass = (dec_raw == 2'b00);

    // ==========================================================
    // Clock source per channel
    rcs_src_t [3:0] src_idx;
    rcs_src_t       master_idx;

    assign master_idx = {1'b0, pin_d_sel, pin_b_sel};

    always_comb begin
        for (int i = 0; i < `RCS_NUM_CH; i++) begin
            unique case (src_sel)
                RCS_LVL_LOW:  src_idx[i] = `RCS_REF_IDX;
                RCS_LVL_MID:  src_idx[i] = rcs_src_t'(i);
                RCS_LVL_HIGH: begin
                    if (bond == RCS_BOND_DUAL) begin
                        if (i < 2) begin
                            src_idx[i] = pin_b_sel ? `RCS_CH_B : `RCS_CH_A;
                        end else begin
                            src_idx[i] = pin_d_sel ? `RCS_CH_D : `RCS_CH_C;
                        end
                    end else begin
                        src_idx[i] = master_idx;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Pin drivers
    logic       ref_dly_r;
    logic [3:0] pin_lvl;
    logic [3:0] pin_oe;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ref_dly_r <= 1'b0;
        end else begin
            ref_dly_r <= trk_level[`RCS_REF_IDX];
        end
    end

    always_comb begin
        for (int i = 0; i < `RCS_NUM_CH; i++) begin
            if (src_sel == RCS_LVL_LOW) begin
                // Rate select ignored; pin C one cycle behind pin A
                pin_lvl[i] = (i == 2) ? ref_dly_r : trk_level[`RCS_REF_IDX];
                pin_oe[i]  = (i == 0) || (i == 2);
            end else begin
                pin_lvl[i] = rate_half ? trk_half[src_idx[i]]
                                       : trk_level[src_idx[i]];
                pin_oe[i]  = (src_sel == RCS_LVL_MID) || (i == 0) || (i == 2);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rx_clock_pin_pair_p  <= `RCS_RST_PIN;
            o_rx_clock_pin_pair_n  <= `RCS_RST_PIN;
            o_rx_clock_pin_pair_oe <= `RCS_RST_PIN;
        end else begin
            o_rx_clock_pin_pair_p  <= pin_lvl;
            o_rx_clock_pin_pair_n  <= ~pin_lvl;
            o_rx_clock_pin_pair_oe <= pin_oe;
        end
    end

    // ==========================================================
    // Channel output registers
    logic [3:0]      load;
    logic [3:0][7:0] data_nxt;
    logic [3:0][2:0] stat_nxt;
    logic [3:0]      par_nxt;

    always_comb begin
        for (int i = 0; i < `RCS_NUM_CH; i++) begin
            load[i] = trk_rise[src_idx[i]];
            if (dec_bypass) begin
                data_nxt[i] = i_raw_char[i][`RCS_RAW_DATA_MSB:`RCS_RAW_DATA_LSB];
                stat_nxt[i] = {i_raw_comma[i], i_raw_char[i][1:0]};
                par_nxt[i]  = ~^i_raw_char[i][`RCS_RAW_DATA_MSB:`RCS_RAW_DATA_LSB];
            end else begin
                data_nxt[i] = i_dec_data[i];
                stat_nxt[i] = i_dec_status[i];
                par_nxt[i]  = i_dec_parity[i];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_channel_parallel_data_out <= {`RCS_NUM_CH{`RCS_RST_DATA}};
            o_channel_status_out        <= {`RCS_NUM_CH{`RCS_RST_STAT}};
            o_channel_odd_parity_out    <= '0;
            o_channel_load              <= '0;
        end else begin
            o_channel_load <= load;
            for (int i = 0; i < `RCS_NUM_CH; i++) begin
                if (load[i]) begin
                    o_channel_parallel_data_out[i] <= data_nxt[i];
                    o_channel_status_out[i]        <= stat_nxt[i];
                    o_channel_odd_parity_out[i]    <= par_nxt[i];
                end
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_low_held;
        (src_sel == RCS_LVL_LOW) [*2];
    endsequence

    sequence s_ref_edge;
        (src_sel == RCS_LVL_LOW) && trk_rise[`RCS_REF_IDX];
    endsequence

    property p_low_loads_ref;
        s_ref_edge |=> o_channel_load == 4'hF
                       && o_channel_parallel_data_out[3] == $past(data_nxt[3]);
    endproperty
    a_low_loads_ref: assert property (p_low_loads_ref)
        else $error("reference edge did not load all channels");

    property p_low_bd_off;
        s_low_held |=> !o_rx_clock_pin_pair_oe[1] && !o_rx_clock_pin_pair_oe[3];
    endproperty
    a_low_bd_off: assert property (p_low_bd_off)
        else $error("B or D clock driver enabled in reference mode");

    property p_low_phase;
        s_low_held ##0 (src_sel == RCS_LVL_LOW) [*1] |=>
            o_rx_clock_pin_pair_p[0] == $past(trk_level[`RCS_REF_IDX])
            && o_rx_clock_pin_pair_p[2] == $past(trk_level[`RCS_REF_IDX], 2);
    endproperty
    a_low_phase: assert property (p_low_phase)
        else $error("reference copies on A and C out of phase order");

    property p_mid_pairs;
        (src_sel == RCS_LVL_MID) |=> o_rx_clock_pin_pair_oe == 4'hF
            && o_rx_clock_pin_pair_n == ~o_rx_clock_pin_pair_p;
    endproperty
    a_mid_pairs: assert property (p_mid_pairs)
        else $error("pin pairs not complementary and driven in recovered mode");

    property p_half_toggle;
        (src_sel == RCS_LVL_MID) && rate_half && trk_rise[1]
            ##1 (src_sel == RCS_LVL_MID) && rate_half
            |=> o_rx_clock_pin_pair_p[1] != $past(o_rx_clock_pin_pair_p[1]);
    endproperty
    a_half_toggle: assert property (p_half_toggle)
        else $error("half-rate clock did not toggle on its edge");

    property p_full_rate;
        (src_sel != RCS_LVL_LOW) && !rate_half
            |=> o_rx_clock_pin_pair_p[0] == $past(trk_level[src_idx[0]]);
    endproperty
    a_full_rate: assert property (p_full_rate)
        else $error("pin A does not follow the selected clock at character rate");

    property p_quad_master;
        (src_sel == RCS_LVL_HIGH) && (bond != RCS_BOND_DUAL)
            |=> o_rx_clock_pin_pair_p[0] == o_rx_clock_pin_pair_p[2]
                && !o_rx_clock_pin_pair_oe[1] && o_rx_clock_pin_pair_oe[2];
    endproperty
    a_quad_master: assert property (p_quad_master)
        else $error("A and C do not carry one master clock");

    property p_dual_pair;
        (src_sel == RCS_LVL_HIGH) && (bond == RCS_BOND_DUAL)
            |-> load[0] == load[1] && load[2] == load[3]
                && load[0] == trk_rise[pin_b_sel ? 1 : 0];
    endproperty
    a_dual_pair: assert property (p_dual_pair)
        else $error("pair channels not loaded by their pair clock");

    property p_bypass_raw;
        dec_bypass && load[2] |=> o_channel_parallel_data_out[2]
            == $past(i_raw_char[2][`RCS_RAW_DATA_MSB:`RCS_RAW_DATA_LSB]);
    endproperty
    a_bypass_raw: assert property (p_bypass_raw)
        else $error("raw character not passed in bypass mode");
endmodule : rcs_receive_clock_select

// File: tb/rcs_host_capture.sv
// Host capture model: latches each channel's outputs on its load strobe.
// Assumes strobes and data are synchronous to i_clk.
`timescale 1ns/1ns

module rcs_host_capture (
    input  wire logic            i_clk,
    input  wire logic [3:0]      i_load,
    input  wire logic [3:0][7:0] i_data,
    input  wire logic [3:0][2:0] i_status,
    input  wire logic [3:0]      i_parity,
    output logic      [3:0][7:0] o_data,
    output logic      [3:0][2:0] o_status,
    output logic      [3:0]      o_parity
);
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (i_load[k]) begin
                o_data[k]   <= i_data[k];
                o_status[k] <= i_status[k];
                o_parity[k] <= i_parity[k];
            end
        end
    end
endmodule : rcs_host_capture

// File: tb/test_rcs_receive_clock_select.sv
// Self-checking bench for the receive clock selection block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end

module test_rcs_receive_clock_select;
    import rcs_pkg::*;
    logic            i_clk = 1'b0;
    logic            i_reset = 1'b1;
    logic [1:0]      sel = RCS_LVL_MID;
    logic            rate = 1'b0;
    logic [1:0]      dec = 2'b01;
    logic [3:0]      mode = 4'h0;
    logic            ref_clk = 1'b0;
    logic [3:0]      rc = 4'h0;
    logic [3:0][9:0] raw = '0;
    logic [3:0]      comma = 4'h0;
    logic [3:0][7:0] dd = '0;
    logic [3:0][2:0] ds = '0;
    logic [3:0]      dp = 4'h0;
    logic [3:0]      drv = 4'h0;
    logic [3:0]      pin, o_p, o_n, o_oe, o_ld, o_par, c_par, prev;
    logic [3:0][7:0] o_d, c_d;
    logic [3:0][2:0] o_s, c_s;
    logic [4:0]      h [0:5];
    int              cyc = 0;
    int              mismatches = 0;
    int              n_checks = 0;

    // Tri-state style resolution of all four pins; the design drives a pin when its enable is set
    for (genvar g = 0; g < 4; g++) begin : g_pin
        assign pin[g] = o_oe[g] ? o_p[g] : drv[g];
    end

    rcs_receive_clock_select dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_output_clock_source_select(sel),
        .i_recovered_clock_rate_select(rate), .i_decoder_mode_select(dec),
        .i_rx_mode(mode), .i_reference_clock_in(ref_clk), .i_recovered_clock(rc),
        .i_raw_char(raw), .i_raw_comma(comma), .i_dec_data(dd), .i_dec_status(ds),
        .i_dec_parity(dp), .i_rx_clock_pin_pair_p(pin), .o_rx_clock_pin_pair_p(o_p),
        .o_rx_clock_pin_pair_n(o_n), .o_rx_clock_pin_pair_oe(o_oe),
        .o_channel_parallel_data_out(o_d), .o_channel_status_out(o_s),
        .o_channel_odd_parity_out(o_par), .o_channel_load(o_ld));

    rcs_host_capture host (.i_clk(i_clk), .i_load(o_ld), .i_data(o_d), .i_status(o_s),
        .i_parity(o_par), .o_data(c_d), .o_status(c_s), .o_parity(c_par));

    initial begin
        forever #10 i_clk = ~i_clk;
    end

    // Recovered clocks of 160 ns period, 40 ns apart per channel; reference 240 ns
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        for (int k = 0; k < 4; k++) rc[k] <= ((cyc + 2 * k) % 8) < 4;
        ref_clk <= (cyc % 12) < 6;
        h[0] <= {ref_clk, rc};
        for (int j = 1; j < 6; j++) h[j] <= h[j - 1];
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    // Source index of a pin (0..3 channels, 4 reference)
    function automatic int src(int k);
        if (sel == RCS_LVL_LOW) return 4;
        if (sel != RCS_LVL_HIGH) return k;
        if (mode == 4'h3 || mode == 4'h5) return (k < 2) ? (drv[1] ? 1 : 0) : (drv[3] ? 3 : 2);
        return {drv[3], drv[1]};
    endfunction : src

    task automatic chk_pin(int k, int d);
        int s;
        s = src(k);
        // Half-rate copy toggles one cycle after the full-rate path
        if (rate && sel != RCS_LVL_LOW)
            `CHK(o_p[k] != prev[k], h[d + 1][s] & ~h[d + 2][s])
        else
            `CHK(o_p[k], h[d][s])
    endtask : chk_pin

    task automatic run(string name, int n);
        @(negedge i_clk);
        prev = o_p;
        for (int i = 0; i < n; i++) begin
            @(negedge i_clk);
            `CHK(o_n, ~o_p)
            `CHK(o_oe, (sel == RCS_LVL_MID) ? 4'hF : 4'h5)
            for (int k = 0; k < 4; k++)
                `CHK(o_ld[k], h[2][src(k)] & ~h[3][src(k)])
            chk_pin(0, 2);
            chk_pin(2, (sel == RCS_LVL_LOW) ? 3 : 2);
            if (sel == RCS_LVL_MID) begin
                chk_pin(1, 2);
                chk_pin(3, 2);
            end
            prev = o_p;
        end
        $display("test %s done", name);
    endtask : run

    task automatic cfg(logic [1:0] s, logic r, logic [3:0] m, logic [3:0] p);
        @(posedge i_clk);
        sel  <= s;
        rate <= r;
        mode <= m;
        drv  <= p;
        repeat (8) @(posedge i_clk);
    endtask : cfg

    task automatic t_mid;
        for (int r = 0; r < 2; r++) begin
            cfg(RCS_LVL_MID, r[0], 4'h0, 4'h0);
            run("mid", 40);
        end
    endtask : t_mid

    task automatic t_low;
        for (int r = 0; r < 2; r++) begin
            cfg(RCS_LVL_LOW, r[0], 4'h6, 4'hA);
            run("low", 40);
        end
    endtask : t_low

    task automatic t_dual;
        for (int p = 0; p < 8; p++) begin
            cfg(RCS_LVL_HIGH, p[2], (p[0] ^ p[1]) ? 4'h5 : 4'h3, {p[1], 1'b0, p[0], 1'b0});
            run("dual", 24);
        end
    endtask : t_dual

    task automatic t_quad;
        logic [3:0] ms [4] = '{4'h0, 4'h2, 4'h6, 4'h8};
        for (int p = 0; p < 16; p++) begin
            cfg(RCS_LVL_HIGH, p[3], ms[p[3:2]], {p[1], 1'b0, p[0], 1'b0});
            run("quad", 24);
        end
    endtask : t_quad

    task automatic t_data;
        // Select reaches MID before the decoder is bypassed
        cfg(RCS_LVL_MID, 1'b0, 4'h0, 4'h0);
        dec   <= 2'b00;
        raw   <= {10'h2D3, 10'h1A5, 10'h3FF, 10'h001};
        comma <= 4'h5;
        dd    <= {8'hC3, 8'h5A, 8'h81, 8'h7E};
        ds    <= {3'h7, 3'h2, 3'h5, 3'h1};
        dp    <= 4'h9;
        run("bypass", 24);
        for (int k = 0; k < 4; k++) begin
            `CHK(c_d[k], raw[k][9:2])
            `CHK(c_s[k], {comma[k], raw[k][1:0]})
            `CHK(^{c_d[k], c_par[k]}, 1'b1)
        end
        @(posedge i_clk);
        dec <= 2'b10;
        cfg(RCS_LVL_LOW, 1'b0, 4'h0, 4'h0);
        run("decoded", 30);
        for (int k = 0; k < 4; k++) begin
            `CHK(c_d[k], dd[k])
            `CHK(c_s[k], ds[k])
            `CHK(c_par[k], dp[k])
        end
    endtask : t_data

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial begin
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (6) @(posedge i_clk);
        t_mid();
        t_low();
        t_dual();
        t_quad();
        t_data();
        end_sim();
    end
endmodule : test_rcs_receive_clock_select
